/* File: inc/dcf_pkg.sv */
package dcf_pkg;

  // ----------------------------------------
  // Slot geometry
  // ----------------------------------------
  localparam int unsigned SPREAD_FACTOR   = 512;
  localparam int unsigned BITS_PER_SYMBOL = 2;
  localparam int unsigned CHIPS_PER_BIT   = SPREAD_FACTOR / BITS_PER_SYMBOL;
  localparam int unsigned SLOT_BITS       = 10;
  localparam int unsigned TPC_BITS        = 2;
  localparam int unsigned FMT_BITS        = 0;
  localparam int unsigned CCC_BITS        = 4;
  localparam int unsigned PILOT_BITS      = 4;
  localparam int unsigned SLOTS_PER_FRAME = 15;

  // Field positions in the slot word, bit 9 leaves first
  localparam int unsigned TPC_LSB   = 8;
  localparam int unsigned CCC_LSB   = 4;
  localparam int unsigned PILOT_LSB = 0;

  localparam logic [7:0] CHIP_LAST  = 8'(CHIPS_PER_BIT - 1);
  localparam logic [3:0] BIT_LAST   = 4'(SLOT_BITS - 1);
  localparam logic [3:0] SLOT_LAST  = 4'(SLOTS_PER_FRAME - 1);
  localparam logic [3:0] SLOT_COUNT = 4'(SLOTS_PER_FRAME);

  // ----------------------------------------
  // Field codes and command queue sizing
  // ----------------------------------------
  localparam logic [1:0] TPC_UP      = 2'h3;
  localparam logic [1:0] TPC_DOWN    = 2'h0;
  localparam logic [3:0] CCC_ESTOP   = 4'hF;
  localparam logic [3:0] CCC_SOM     = 4'hA;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned CMD_WIDTH  = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PREAM = 2'b01,
    ST_START = 2'b10,
    ST_MSG   = 2'b11
  } dcf_state_e;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'b00,
    CMD_ESTOP = 2'b01
  } dcf_cmd_e;

  typedef enum logic [1:0] {
    CL_OFF   = 2'b00,
    CL_MODE1 = 2'b01,
    CL_MODE2 = 2'b10
  } dcf_cl_e;

  typedef struct packed {
    logic [SLOT_BITS-1:0] ant1;
    logic [SLOT_BITS-1:0] ant2;
    logic [SLOT_BITS-1:0] tx_mask;
  } dcf_slot_s;

endpackage

/* File: hdl/dcf_fifo.sv */
`timescale 1ns/1ps
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int unsigned WIDTH = CMD_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_fifo_bounds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    count_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");

endmodule

/* File: hdl/dcf_formatter.sv */
`timescale 1ns/1ps
// How it works
// RULE_01: Mode 1: primary pilots ant1, orthogonal ant2
// RULE_02: Mode 2: same primary pilot both antennas
// RULE_03: Fixed spreading factor 512, lowest-rate format
// RULE_04: Ten bits: 2 power, 0 format, 4 command, 4 pilot
// RULE_05: All fifteen slots of each frame sent
// RULE_06: Pilot field follows slot index pattern
// RULE_07: Preamble uses the message slot layout
// RULE_08: Preamble pilots run slots 15-N to 14
// RULE_09: Preamble format field all ones (zero width)
// RULE_10: Command field silent unless command requested
// RULE_11: Emergency stop sends 1111, one pattern each
// RULE_12: No emergency stop during start window
// RULE_13: Start indicator throughout window, length from input
// RULE_14: Start indicator pattern is 1010
// RULE_15: Preamble length supplied before transmission starts
// RULE_16: Power bits 11 up, 00 down
// RULE_17: Frame counter after preamble gates both commands
// RULE_18: Order power, format, command, pilot, MSB first
module dcf_formatter
  import dcf_pkg::*;
#(
  parameter logic [3:0] PILOT_MAIN [SLOTS_PER_FRAME] = '{
    4'hF, 4'hC, 4'hD, 4'hC, 4'hE, 4'hF, 4'hF, 4'hE,
    4'hD, 4'hF, 4'hD, 4'hE, 4'hE, 4'hC, 4'hC},
  parameter logic [3:0] PILOT_DIV [SLOTS_PER_FRAME] = '{
    4'h6, 4'hA, 4'hE, 4'hA, 4'h2, 4'h6, 4'h6, 4'h2,
    4'hE, 4'h6, 4'hE, 4'h2, 4'h2, 4'hA, 4'hA}
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // Chip timing
  input  wire logic                 i_chip_tick,
  // Configuration
  input  wire logic [3:0]           i_preamble_length,
  input  wire logic [3:0]           i_start_window_frames,
  input  wire dcf_cl_e              i_cl_mode,
  // Session control
  input  wire logic                 i_start,
  input  wire logic                 i_stop,
  input  wire logic                 i_power_up,
  // Command requests
  input  wire logic                 i_cmd_valid,
  output logic                      o_cmd_ready,
  input  wire logic [CMD_WIDTH-1:0] i_cmd,
  // Air side bit stream
  output logic                      o_bit_stb,
  output logic                      o_ant1_bit,
  output logic                      o_ant2_bit,
  output logic                      o_ant1_on,
  output logic                      o_ant2_on,
  // Status
  output dcf_state_e                o_state,
  output logic [3:0]                o_slot_index,
  output logic                      o_frame_start
);

  // ----------------------------------------
  // Chip, bit and slot timing
  // ----------------------------------------
  logic [7:0] chip_cnt_r;
  logic [3:0] bit_idx_r;
  logic       bit_end;
  logic       slot_end;

  // One bit every SF/2 chips; slots run back to back with no gaps
  assign bit_end  = i_chip_tick && (chip_cnt_r == CHIP_LAST); // [RULE_03]
  assign slot_end = bit_end && (bit_idx_r == BIT_LAST);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chip_cnt_r <= '0;
    end else if (i_chip_tick) begin
      chip_cnt_r <= (chip_cnt_r == CHIP_LAST) ? '0 : chip_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_idx_r <= '0;
    end else if (bit_end) begin
      bit_idx_r <= (bit_idx_r == BIT_LAST) ? '0 : bit_idx_r + 4'h1;
    end
  end

  // ----------------------------------------
  // Pending session requests
  // ----------------------------------------
  logic start_pend_r;
  logic stop_pend_r;
  logic start_take;
  logic stop_take;

  // A request arriving in the cycle it is consumed stays pending
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_pend_r <= 1'b0;
      stop_pend_r  <= 1'b0;
    end else begin
      start_pend_r <= i_start || (start_pend_r && !start_take);
      stop_pend_r  <= i_stop || (stop_pend_r && !stop_take);
    end
  end

  // ----------------------------------------
  // Command queue
  // ----------------------------------------
  logic                 q_valid;
  logic                 q_pop;
  logic [CMD_WIDTH-1:0] q_cmd;

  dcf_fifo #(
    .WIDTH (CMD_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (i_cmd_valid),
    .o_in_ready  (o_cmd_ready),
    .i_in_data   (i_cmd),
    .o_out_valid (q_valid),
    .i_out_ready (q_pop),
    .o_out_data  (q_cmd)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  dcf_state_e state_r;
  dcf_state_e state_nxt;
  logic [3:0] slot_r;
  logic [3:0] slot_nxt;
  logic [3:0] frame_cnt_r;
  logic [3:0] frame_cnt_nxt;

  always_comb begin
    state_nxt     = state_r;
    slot_nxt      = (slot_r == SLOT_LAST) ? '0 : slot_r + 4'h1; // [RULE_05]
    frame_cnt_nxt = frame_cnt_r;
    start_take    = 1'b0;
    stop_take     = 1'b0;
    case (state_r)
      ST_IDLE: begin
        slot_nxt = '0;
        if (start_pend_r) begin
          start_take = 1'b1;
          frame_cnt_nxt = '0;
          if (i_preamble_length != '0) begin // [RULE_15]
            state_nxt = ST_PREAM;
            // Preamble ends exactly on a frame boundary
            slot_nxt  = SLOT_COUNT - i_preamble_length; // [RULE_08]
          end else if (i_start_window_frames != '0) begin
            state_nxt = ST_START;
          end else begin
            state_nxt = ST_MSG;
          end
        end
      end
      ST_PREAM: begin
        if (slot_r == SLOT_LAST) begin
          frame_cnt_nxt = '0; // [RULE_17]
          state_nxt = (i_start_window_frames != '0) ? ST_START : ST_MSG;
        end
      end
      ST_START: begin
        if (slot_r == SLOT_LAST) begin
          frame_cnt_nxt = frame_cnt_r + 4'h1; // [RULE_17]
          if (frame_cnt_nxt >= i_start_window_frames) begin // [RULE_13]
            state_nxt = ST_MSG;
          end
        end
      end
      ST_MSG: begin
        if (stop_pend_r) begin
          stop_take = 1'b1;
          state_nxt = ST_IDLE;
          slot_nxt  = '0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        slot_nxt  = '0;
      end
    endcase
    if (!slot_end) begin
      state_nxt     = state_r;
      slot_nxt      = slot_r;
      frame_cnt_nxt = frame_cnt_r;
      start_take    = 1'b0;
      stop_take     = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r     <= ST_IDLE;
      slot_r      <= '0;
      frame_cnt_r <= '0;
    end else begin
      state_r     <= state_nxt;
      slot_r      <= slot_nxt;
      frame_cnt_r <= frame_cnt_nxt;
    end
  end

  // ----------------------------------------
  // Slot word assembly
  // ----------------------------------------
  dcf_slot_s  slot_w;
  logic [3:0] ccc;
  logic       ccc_on;
  logic [3:0] pilot1;
  logic [3:0] pilot2;
  logic [1:0] power_control_bits;

  // Stop is held in the queue, not dropped, while the window runs
  assign q_pop = slot_end && (state_nxt == ST_MSG) && (state_r == ST_MSG)
                 && q_valid; // [RULE_12]

  always_comb begin
    ccc    = '0;
    ccc_on = 1'b0;
    if (state_nxt == ST_START) begin
      ccc    = CCC_SOM; // [RULE_14]
      ccc_on = 1'b1;
    end else if (q_pop && (dcf_cmd_e'(q_cmd) == CMD_ESTOP)) begin
      ccc    = CCC_ESTOP; // [RULE_11]
      ccc_on = 1'b1;
    end
  end

  assign power_control_bits    = i_power_up ? TPC_UP : TPC_DOWN; // [RULE_16]
  assign pilot1 = PILOT_MAIN[slot_nxt]; // [RULE_06]
  // Mode 2 repeats the primary pattern, mode 1 uses the orthogonal one
  assign pilot2 = (i_cl_mode == CL_MODE1) ? PILOT_DIV[slot_nxt] : pilot1; // [RULE_01] [RULE_02]

  // Same layout in preamble and message; format field has no width
  always_comb begin
    slot_w.ant1    = {power_control_bits, ccc, pilot1}; // [RULE_04] [RULE_07] [RULE_09] [RULE_18]
    slot_w.ant2    = {power_control_bits, ccc, pilot2};
    slot_w.tx_mask = {2'b11, {CCC_BITS{ccc_on}}, 4'hF}; // [RULE_10]
  end

  // ----------------------------------------
  // Serialiser
  // ----------------------------------------
  dcf_slot_s sh_r;
  logic      active_r;
  logic      stb_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_r     <= '0;
      active_r <= 1'b0;
    end else if (slot_end) begin
      sh_r     <= slot_w;
      active_r <= (state_nxt != ST_IDLE);
    end else if (bit_end) begin
      sh_r.ant1    <= {sh_r.ant1[SLOT_BITS-2:0], 1'b0}; // [RULE_18]
      sh_r.ant2    <= {sh_r.ant2[SLOT_BITS-2:0], 1'b0};
      sh_r.tx_mask <= {sh_r.tx_mask[SLOT_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stb_r <= 1'b0;
    end else begin
      stb_r <= bit_end;
    end
  end

  assign o_bit_stb     = stb_r;
  assign o_ant1_bit    = sh_r.ant1[SLOT_BITS-1];
  assign o_ant2_bit    = sh_r.ant2[SLOT_BITS-1];
  assign o_ant1_on     = active_r && sh_r.tx_mask[SLOT_BITS-1];
  assign o_ant2_on     = o_ant1_on && (i_cl_mode != CL_OFF);
  assign o_state       = state_r;
  assign o_slot_index  = slot_r;
  assign o_frame_start = stb_r && active_r && (bit_idx_r == '0) && (slot_r == '0);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_slot_load;
    slot_end && (state_nxt == ST_START);
  endsequence

  sequence s_som_on_air;
    (sh_r.ant1[7:4] == CCC_SOM) && (sh_r.tx_mask[7:4] == 4'hF);
  endsequence

  chk_som_pattern: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_14]
    s_slot_load |=> s_som_on_air)
    else $error("start indicator pattern missing");

  chk_estop_window: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_12]
    (state_r == ST_START) |-> !q_pop)
    else $error("command popped during start window");

  chk_estop_code: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_11]
    (q_pop && dcf_cmd_e'(q_cmd) == CMD_ESTOP) |=> (sh_r.ant1[7:4] == CCC_ESTOP))
    else $error("emergency stop not 1111");

  chk_ccc_silent: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_10]
    (slot_end && state_nxt == ST_MSG && !q_pop) |=> (sh_r.tx_mask[7:4] == 4'h0))
    else $error("command field sent without request");

  chk_preamble_start: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_08]
    (state_r == ST_IDLE && state_nxt == ST_PREAM)
      |=> (slot_r == SLOT_COUNT - $past(i_preamble_length)))
    else $error("preamble first slot wrong");

  chk_preamble_end: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_08]
    ($past(state_r) == ST_PREAM && state_r != ST_PREAM) |-> ($past(slot_r) == SLOT_LAST))
    else $error("preamble did not end at slot 14");

  chk_slot_wrap: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_05]
    (slot_end && state_r != ST_IDLE && state_nxt != ST_IDLE && slot_r == SLOT_LAST)
      |=> (slot_r == 4'h0))
    else $error("slot index did not wrap");

  chk_div_pilot: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_01]
    (slot_end && i_cl_mode == CL_MODE1) |=> (sh_r.ant2[3:0] == PILOT_DIV[slot_r]))
    else $error("mode 1 antenna 2 pilot wrong");

  chk_same_pilot: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_02]
    (slot_end && i_cl_mode == CL_MODE2) |=> (sh_r.ant2 == sh_r.ant1))
    else $error("mode 2 antennas differ");

  chk_tpc_code: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_16]
    slot_end |=> (sh_r.ant1[9:8] == ($past(i_power_up) ? TPC_UP : TPC_DOWN)))
    else $error("power control bits wrong");

  chk_main_pilot: assert property (@(posedge i_clk) disable iff (!i_arst_n) // [RULE_06]
    slot_end |=> (sh_r.ant1[3:0] == PILOT_MAIN[slot_r]))
    else $error("antenna 1 pilot wrong");

endmodule

/* File: tb/dcf_ue_model.sv */
`timescale 1ns/1ps
module dcf_ue_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Air side
  input  wire logic       i_bit_stb,
  input  wire logic       i_ant1_bit,
  input  wire logic       i_ant2_bit,
  input  wire logic       i_ant1_on,
  input  wire logic       i_ant2_on,
  input  wire logic [3:0] i_slot_index,
  // Received slot
  output logic            o_word_valid,
  output logic [3:0]      o_slot,
  output logic [9:0]      o_w1,
  output logic [9:0]      o_w2,
  output logic [9:0]      o_m1,
  output logic [9:0]      o_m2
);
  logic [3:0] cnt_r;
  logic       new_slot;

  assign new_slot = (i_slot_index != o_slot);

  // A moving slot index opens a word and realigns the bit count
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r        <= 4'h0;
      o_slot       <= 4'hF;
      o_word_valid <= 1'b0;
      o_w1         <= 10'h000;
      o_w2         <= 10'h000;
      o_m1         <= 10'h000;
      o_m2         <= 10'h000;
    end else begin
      o_word_valid <= 1'b0;
      if (i_bit_stb && (new_slot || cnt_r != 4'h0)) begin
        o_slot       <= i_slot_index;
        o_w1         <= {o_w1[8:0], i_ant1_bit};
        o_w2         <= {o_w2[8:0], i_ant2_bit};
        o_m1         <= {o_m1[8:0], i_ant1_on};
        o_m2         <= {o_m2[8:0], i_ant2_on};
        cnt_r        <= new_slot ? 4'h1 : cnt_r + 4'h1;
        o_word_valid <= (cnt_r == 4'h9) && !new_slot;
      end
    end
  end
endmodule

/* File: tb/tb_dcf_formatter.sv */
`timescale 1ns/1ps
module tb_dcf_formatter
  import dcf_pkg::*;
;
  localparam logic [3:0] MAIN_P [SLOTS_PER_FRAME] = '{
    4'hF, 4'hC, 4'hD, 4'hC, 4'hE, 4'hF, 4'hF, 4'hE,
    4'hD, 4'hF, 4'hD, 4'hE, 4'hE, 4'hC, 4'hC};
  localparam logic [3:0] DIV_P [SLOTS_PER_FRAME] = '{
    4'h6, 4'hA, 4'hE, 4'hA, 4'h2, 4'h6, 4'h6, 4'h2,
    4'hE, 4'h6, 4'hE, 4'h2, 4'h2, 4'hA, 4'hA};

  logic       clk, arst_n, start, stop, pu, cmd_valid, cmd_ready;
  logic       bit_stb, a1b, a2b, a1on, a2on, fs, wv;
  logic [1:0] cmd;
  logic [3:0] slot_idx, rx_slot;
  logic [9:0] w1, w2, m1, m2;
  dcf_cl_e    mode;
  dcf_state_e st;
  int         mismatches, checks, cyc, last_cyc, fs_cnt, k, pushed, n;

  dcf_formatter #(.PILOT_MAIN(MAIN_P), .PILOT_DIV(DIV_P)) u_dcf_formatter (
    .i_clk(clk), .i_arst_n(arst_n), .i_chip_tick(1'b1),
    .i_preamble_length(4'h2),
    .i_start_window_frames(4'h1),
    .i_cl_mode(mode), .i_start(start), .i_stop(stop), .i_power_up(pu),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd(cmd),
    .o_bit_stb(bit_stb), .o_ant1_bit(a1b), .o_ant2_bit(a2b), .o_ant1_on(a1on),
    .o_ant2_on(a2on), .o_state(st), .o_slot_index(slot_idx), .o_frame_start(fs));

  dcf_ue_model u_dcf_ue_model (
    .i_clk(clk), .i_arst_n(arst_n), .i_bit_stb(bit_stb), .i_ant1_bit(a1b),
    .i_ant2_bit(a2b), .i_ant1_on(a1on), .i_ant2_on(a2on), .i_slot_index(slot_idx),
    .o_word_valid(wv), .o_slot(rx_slot), .o_w1(w1), .o_w2(w2), .o_m1(m1), .o_m2(m2));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (fs === 1'b1) fs_cnt++;
  end

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic chk_word(input logic [9:0] got, input logic [9:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic push_cmd(input logic [1:0] c);
    int w;
    w = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = c;
    do begin
      @(posedge clk);
      w++;
    end while (cmd_ready !== 1'b1 && w < 100);
    if (cmd_ready === 1'b1) pushed++;
  endtask

  // Inputs change on the last bit so the next slot load sees them settled
  task automatic run_slot(input int i);
    int         s, w;
    logic       con;
    logic [3:0] ccc;
    logic [9:0] e1, mk, mk2;
    dcf_state_e est;
    w = 0;
    s = (i < 2) ? 13 + i : (i < 17) ? i - 2 : i - 17;
    est = (i < 2) ? ST_PREAM : (i < 17) ? ST_START : ST_MSG;
    // Nothing pops on the window edge, so the queued stop leaves one slot later
    con = (i >= 2) && (i < 17 || i == 18);
    ccc = (i < 17) ? CCC_SOM : CCC_ESTOP;
    do begin
      @(negedge clk);
      w++;
    end while (wv !== 1'b1 && w < 3000);
    if (w >= 3000) begin
      mismatches++;
      $display("ERROR %0t no slot word", $time);
    end
    if (i > 0) chk_val(16'(cyc - last_cyc), 16'hA00, "slot span");
    last_cyc = cyc;
    mk = {2'b11, con ? 4'hF : 4'h0, 4'hF};
    mk2 = (mode == CL_OFF) ? 10'h000 : mk;
    e1 = {pu ? TPC_UP : TPC_DOWN, con ? ccc : 4'h0, MAIN_P[s]};
    chk_val(16'(rx_slot), 16'(s), "slot index");
    chk_val(16'(st), 16'(est), "state");
    chk_word(m1, mk, "ant1 on mask");
    chk_word(w1 & mk, e1, "ant1 word");
    chk_word(m2, mk2, "ant2 on mask");
    e1[3:0] = (mode == CL_MODE1) ? DIV_P[s] : MAIN_P[s];
    chk_word(w2 & mk2, e1 & mk2, "ant2 word");
    pu = ((i + 1) % 2 == 0);
    mode = ((i + 1) % 3 == 0) ? CL_MODE1 : ((i + 1) % 3 == 1) ? CL_MODE2 : CL_OFF;
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    pu = 1'b1;
    cmd_valid = 1'b0;
    cmd = 2'h0;
    mode = CL_MODE1;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (st === ST_IDLE && n < 3000) begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < 20; i++) begin
      if (i == 2) begin
        push_cmd(2'(CMD_ESTOP));
        for (k = 0; k < 31; k++) push_cmd(2'(CMD_NONE));
        chk_val(16'(pushed), 16'h0020, "fifo fill count");
        // A full queue must refuse one more request
        push_cmd(2'(CMD_NONE));
        @(negedge clk);
        cmd_valid = 1'b0;
        chk_val(16'(pushed), 16'h0020, "fifo refused push");
        chk_val({15'h0000, cmd_ready}, 16'h0000, "queue full");
      end
      if (i == 19) chk_val({15'h0000, cmd_ready}, 16'h0001, "queue popped");
      run_slot(i);
    end
    stop = 1'b1;
    @(negedge clk);
    stop = 1'b0;
    n = 0;
    while (st !== ST_IDLE && n < 3000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk_val(16'(st), 16'(ST_IDLE), "stopped state");
    chk_val({15'h0000, a1on}, 16'h0000, "idle silent");
    chk_val(16'(fs_cnt), 16'h0002, "frame starts");
    // Idle never pops: only the two message-slot pops made room
    for (k = 0; k < 3; k++) push_cmd(2'(CMD_NONE));
    @(negedge clk);
    cmd_valid = 1'b0;
    chk_val(16'(pushed), 16'h0022, "fifo drain count");
    chk_val({15'h0000, cmd_ready}, 16'h0000, "fifo full again");
    tally_and_finish();
  end

  initial begin
    #400000;
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
